/* pkg/iet_pkg.sv */
// Constants for the cascaded interrupt trigger-mode block
package iet_pkg;
  localparam logic [15:0] TRIG_LOW_ADDR   = 16'h04d0;
  localparam logic [15:0] TRIG_HIGH_ADDR  = 16'h04d1;
  localparam logic [15:0] MASTER_CMD_ADDR = 16'h0020;
  localparam logic [15:0] SLAVE_CMD_ADDR  = 16'h00a0;
  localparam int          INIT_SEL_BIT    = 4;
  localparam int          INIT_LEVEL_BIT  = 3;
  localparam logic [7:0]  TRIG_LOW_MASK   = 8'hf8;
  localparam logic [7:0]  TRIG_HIGH_MASK  = 8'hde;
  localparam logic [7:0]  TRIG_RESET      = 8'h00;
  localparam logic [3:0]  CASCADE_LINE    = 4'h2;
endpackage : iet_pkg

/* design/iet_line.sv */
// One request line: pin synchroniser, filter, edge latch and mode select
module iet_line (
  input  wire logic ref_clk_i,  // Block clock
  input  wire logic sys_rst_i,  // Sync reset, high
  input  wire logic ce_i,       // Clock enable
  input  wire logic pin_i,      // Raw request pin
  input  wire logic level_i,    // 1 level mode, 0 edge mode
  input  wire logic clr_i,      // Clear edge latch
  output logic      req_o,      // Request presented
  output logic      filt_o      // Filtered pin level
);
  logic [2:0] sync;
  logic       filt;
  logic       latch;
  logic [2:0] next_sync;
  logic       next_filt;
  logic       next_latch;

  always_comb begin
    next_sync  = {sync[1:0], pin_i};
    next_filt  = filt;
    // Change accepted once second and third stages agree
    if (sync[1] == sync[2]) begin
      next_filt = sync[2];
    end
    // rising edge latch in edge mode only, set beats clear
    // Level mode keeps it empty so a later switch to edge raises no stale request
    next_latch = ~level_i & ((next_filt & ~filt) | (latch & ~clr_i));
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync  <= 3'h0;
      filt  <= 1'b0;
      latch <= 1'b0;
    end else if (ce_i) begin
      sync  <= next_sync;
      filt  <= next_filt;
      latch <= next_latch;
    end
  end

  // level follows pin, edge holds latch
  assign req_o  = level_i ? filt : latch;
  assign filt_o = filt;

  property p_edge_hold;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && !level_i && latch && !clr_i) |=> latch;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge latch lost");

  property p_edge_set;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && !level_i && !filt && sync[1] && sync[2]) |=> latch;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("rising edge not latched");
endmodule : iet_line

/* design/iet_top.sv */
// Cascaded interrupt controller pair with per-line edge/level trigger control
module iet_top (
  input  wire logic        ref_clk_i,           // 250 MHz clock
  input  wire logic        sys_rst_i,           // Sync reset, high
  input  wire logic        ce_i,                // Clock enable
  input  wire logic [15:0] io_addr_i,           // I/O port address
  input  wire logic        io_wr_i,             // I/O write strobe
  input  wire logic        io_rd_i,             // I/O read strobe
  input  wire logic [7:0]  io_wdata_i,          // I/O write data
  output logic      [7:0]  io_rdata_o,          // I/O read data
  input  wire logic        timer0_i,            // Timer 0 request
  input  wire logic        kbd_i,               // Keyboard request
  input  wire logic        rtc_alarm_i,         // Clock alarm request
  input  wire logic        copro_i,             // Coprocessor request
  input  wire logic [10:0] ext_irq_i,           // IRQ3-7, 9-12, 14, 15
  input  wire logic        parity_err_i,        // System parity error
  input  wire logic        bus_channel_check_i, // Bus channel check
  input  wire logic        int_ack_i,           // Interrupt acknowledge pulse
  output logic             cpu_int_o,           // Maskable interrupt to CPU
  output logic      [3:0]  int_num_o,           // Acknowledged line number
  output logic             nmi_o                // Non-maskable interrupt
);
  logic [7:0]  trig_low;
  logic [7:0]  trig_high;
  logic        lvl_master;
  logic        lvl_slave;
  logic [15:0] pin_vec;
  logic [15:0] mode;
  logic [15:0] line_req;
  logic [15:0] line_clr;
  logic [15:0] line_filt;
  logic [7:0]  master_req;
  logic [7:0]  next_trig_low;
  logic [7:0]  next_trig_high;
  logic        next_lvl_master;
  logic        next_lvl_slave;
  logic [7:0]  next_rdata;
  logic        next_cpu_int;
  logic [3:0]  next_int_num;
  logic [15:0] next_clr;
  logic        next_nmi;
  logic [3:0]  ack_line;
  logic        wr_low;
  logic        wr_high;
  logic        wr_init_m;
  logic        wr_init_s;
  logic [2:0]  par_sync;
  logic [2:0]  chk_sync;
  logic        par_filt;
  logic        chk_filt;
  logic        line_filt_nmi;
  logic [2:0]  next_par_sync;
  logic [2:0]  next_chk_sync;
  logic        next_par_filt;
  logic        next_chk_filt;

  // Lowest set bit of eight wins, as in fixed priority mode
  function automatic logic [2:0] pick(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : pick

  // fixed source wiring, line 2 carries no pin
  always_comb begin
    pin_vec     = 16'h0000;
    pin_vec[0]  = timer0_i;
    pin_vec[1]  = kbd_i;
    pin_vec[7:3] = ext_irq_i[4:0];
    pin_vec[8]  = rtc_alarm_i;
    pin_vec[12:9] = ext_irq_i[8:5];
    pin_vec[13] = copro_i;
    pin_vec[15:14] = ext_irq_i[10:9];
  end

  always_comb begin
    mode = {trig_high, trig_low};
    // cascade, timer, keyboard and clock alarm lines stay edge unless overridden
    mode[2] = 1'b0;
    mode[8] = 1'b0;
    mode[1:0] = 2'b00;
    if (lvl_master) begin
      mode[7:0] = 8'hff;
    end
    if (lvl_slave) begin
      mode[15:8] = 8'hff;
    end
  end

  // sixteen lines, level mode lets shared lines work
  for (genvar g = 0; g < 16; g++) begin : g_line
    iet_line u_line (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .pin_i     (pin_vec[g]),
      .level_i   (mode[g]),
      .clr_i     (line_clr[g]),
      .req_o     (line_req[g]),
      .filt_o    (line_filt[g])
    );
  end

  // slave output feeds master input 2
  always_comb begin
    master_req    = line_req[7:0];
    master_req[2] = |line_req[15:8];
  end

  assign wr_low    = io_wr_i && (io_addr_i == iet_pkg::TRIG_LOW_ADDR);
  assign wr_high   = io_wr_i && (io_addr_i == iet_pkg::TRIG_HIGH_ADDR);
  assign wr_init_m = io_wr_i && (io_addr_i == iet_pkg::MASTER_CMD_ADDR)
                     && io_wdata_i[iet_pkg::INIT_SEL_BIT];
  assign wr_init_s = io_wr_i && (io_addr_i == iet_pkg::SLAVE_CMD_ADDR)
                     && io_wdata_i[iet_pkg::INIT_SEL_BIT];

  // Register file
  always_comb begin
    next_trig_low   = trig_low;
    next_trig_high  = trig_high;
    next_lvl_master = lvl_master;
    next_lvl_slave  = lvl_slave;
    if (wr_low) begin
      next_trig_low = io_wdata_i & iet_pkg::TRIG_LOW_MASK;
    end
    // clock alarm and coprocessor bits kept zero
    if (wr_high) begin
      next_trig_high = io_wdata_i & iet_pkg::TRIG_HIGH_MASK;
    end
    if (wr_init_m) begin
      next_lvl_master = io_wdata_i[iet_pkg::INIT_LEVEL_BIT];
    end
    if (wr_init_s) begin
      next_lvl_slave = io_wdata_i[iet_pkg::INIT_LEVEL_BIT];
    end
    next_rdata = io_rdata_o;
    // Command ports read back pending requests
    if (io_rd_i) begin
      case (io_addr_i)
        iet_pkg::TRIG_LOW_ADDR:   next_rdata = trig_low;
        iet_pkg::TRIG_HIGH_ADDR:  next_rdata = trig_high;
        iet_pkg::MASTER_CMD_ADDR: next_rdata = master_req;
        iet_pkg::SLAVE_CMD_ADDR:  next_rdata = line_req[15:8];
        default:                  next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      trig_low   <= iet_pkg::TRIG_RESET;
      trig_high  <= iet_pkg::TRIG_RESET;
      lvl_master <= 1'b0;
      lvl_slave  <= 1'b0;
      io_rdata_o <= 8'h00;
    end else if (ce_i) begin
      trig_low   <= next_trig_low;
      trig_high  <= next_trig_high;
      lvl_master <= next_lvl_master;
      lvl_slave  <= next_lvl_slave;
      io_rdata_o <= next_rdata;
    end
  end

  // Acknowledge resolves master first, then slave through the cascade input
  always_comb begin
    ack_line = {1'b0, pick(master_req)};
    if (ack_line == iet_pkg::CASCADE_LINE) begin
      ack_line = {1'b1, pick(line_req[15:8])};
    end
    next_cpu_int = |master_req;
    next_int_num = int_num_o;
    next_clr     = 16'h0000;
    if (int_ack_i && (|master_req)) begin
      next_int_num = ack_line;
      next_clr[ack_line] = 1'b1;
    end
    // parity and channel check go to NMI only
    next_nmi = line_filt_nmi;
  end

  always_comb begin
    next_par_sync = {par_sync[1:0], parity_err_i};
    next_chk_sync = {chk_sync[1:0], bus_channel_check_i};
    next_par_filt = (par_sync[1] == par_sync[2]) ? par_sync[2] : par_filt;
    next_chk_filt = (chk_sync[1] == chk_sync[2]) ? chk_sync[2] : chk_filt;
  end

  assign line_filt_nmi = par_filt | chk_filt;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      par_sync  <= 3'h0;
      chk_sync  <= 3'h0;
      par_filt  <= 1'b0;
      chk_filt  <= 1'b0;
      cpu_int_o <= 1'b0;
      int_num_o <= 4'h0;
      line_clr  <= 16'h0000;
      nmi_o     <= 1'b0;
    end else if (ce_i) begin
      par_sync  <= next_par_sync;
      chk_sync  <= next_chk_sync;
      par_filt  <= next_par_filt;
      chk_filt  <= next_chk_filt;
      cpu_int_o <= next_cpu_int;
      int_num_o <= next_int_num;
      line_clr  <= next_clr;
      nmi_o     <= next_nmi;
    end
  end

  property p_low_map;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !lvl_master |-> (mode[6:3] == trig_low[6:3]);
  endproperty
  a_low_map: assert property (p_low_map) else $error("low bits not mapped");

  property p_init_level;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && wr_init_s && io_wdata_i[iet_pkg::INIT_LEVEL_BIT]) |=> (mode[15:8] == 8'hff);
  endproperty
  a_init_level: assert property (p_init_level) else $error("init word no override");

  property p_low_rsvd;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && wr_low) |=> (trig_low[2:0] == 3'h0) && (trig_low[7] == $past(io_wdata_i[7]));
  endproperty
  a_low_rsvd: assert property (p_low_rsvd) else $error("low write wrong");

  property p_high_map;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      !lvl_slave |-> (mode[15:14] == trig_high[7:6]) && (mode[12:9] == trig_high[4:1]);
  endproperty
  a_high_map: assert property (p_high_map) else $error("high bits not mapped");

  property p_high_rsvd;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (trig_high[5] == 1'b0) && (trig_high[0] == 1'b0);
  endproperty
  a_high_rsvd: assert property (p_high_rsvd) else $error("reserved high bit set");

  property p_cascade;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && (|line_req[15:8])) |=> cpu_int_o;
  endproperty
  a_cascade: assert property (p_cascade) else $error("slave not cascaded");

  property p_nmi;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (ce_i && (par_filt || chk_filt)) |=> nmi_o;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not raised");

  property p_wiring;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      (pin_vec[8] == rtc_alarm_i) && (pin_vec[13] == copro_i) && (pin_vec[0] == timer0_i);
  endproperty
  a_wiring: assert property (p_wiring) else $error("fixed source miswired");

  property p_reset_edge;
    @(posedge ref_clk_i) sys_rst_i |=> (trig_low == 8'h00) && (trig_high == 8'h00);
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("trigger regs not reset");
endmodule : iet_top

/* tb/iet_cpu_model.sv */
// Host processor model that acknowledges the maskable interrupt after a set delay
module iet_cpu_model (
  input  wire logic       ref_clk_i,  // Block clock
  input  wire logic       sys_rst_i,  // Sync reset, high
  input  wire logic       cpu_int_i,  // Interrupt from block
  input  wire logic       ack_en_i,   // Allow acknowledges
  input  wire logic [3:0] delay_i,    // Cycles before acknowledge
  output logic            int_ack_o   // One-cycle acknowledge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic [2:0] hold_cnt;
  logic [2:0] next_hold_cnt;
  logic       next_int_ack;
  // Hold-off covers the cycles before the block lowers its output
  always_comb begin
    next_wait_cnt = 4'h0;
    next_int_ack  = 1'b0;
    next_hold_cnt = hold_cnt;
    if (hold_cnt != 3'h0) begin
      next_hold_cnt = hold_cnt - 3'h1;
    end else if (cpu_int_i && ack_en_i) begin
      if (wait_cnt == delay_i) begin
        next_int_ack  = 1'b1;
        next_hold_cnt = 3'h6;
      end else begin
        next_wait_cnt = wait_cnt + 4'h1;
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wait_cnt  <= 4'h0;
      hold_cnt  <= 3'h0;
      int_ack_o <= 1'b0;
    end else begin
      wait_cnt  <= next_wait_cnt;
      hold_cnt  <= next_hold_cnt;
      int_ack_o <= next_int_ack;
    end
  end
endmodule : iet_cpu_model

/* tb/tb_top.sv */
// Self-checking testbench for the cascaded interrupt trigger-mode block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i;
  logic        sys_rst_i;
  logic [15:0] io_addr_i;
  logic        io_wr_i;
  logic        io_rd_i;
  logic [7:0]  io_wdata_i;
  logic [7:0]  io_rdata_o;
  logic [15:0] pins;
  logic [1:0]  nmi_src;
  logic        int_ack;
  logic        cpu_int_o;
  logic [3:0]  int_num_o;
  logic        nmi_o;
  logic        ack_en;
  logic        ce;
  logic [3:0]  ack_dly;
  logic [7:0]  rd;
  int          n_mismatch;
  int          total_checks;
  int          cycles;

  iet_top dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .timer0_i(pins[0]), .kbd_i(pins[1]), .rtc_alarm_i(pins[8]),
    .copro_i(pins[13]), .ext_irq_i({pins[15:14], pins[12:9], pins[7:3]}),
    .parity_err_i(nmi_src[0]), .bus_channel_check_i(nmi_src[1]), .int_ack_i(int_ack),
    .cpu_int_o(cpu_int_o), .int_num_o(int_num_o), .nmi_o(nmi_o));
  iet_cpu_model cpu (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .cpu_int_i(cpu_int_o),
    .ack_en_i(ack_en), .delay_i(ack_dly), .int_ack_o(int_ack));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr_i  <= a;
    io_wdata_i <= d;
    io_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    io_wr_i <= 1'b0;
  endtask : io_wr

  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    io_addr_i <= a;
    io_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    io_rd_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 d = io_rdata_o;
  endtask : io_rd

  task automatic pulse(input int n);
    @(posedge ref_clk_i);
    pins[n] <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    pins[n] <= 1'b0;
  endtask : pulse

  task automatic wait_int(input logic exp, input int lim);
    // Step off the edge so a value launched there is settled
    #1;
    for (int i = 0; i < lim && cpu_int_o !== exp; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("cpu_int", {7'h00, cpu_int_o}, {7'h00, exp});
  endtask : wait_int

  task automatic t_regs();
    io_rd(iet_pkg::TRIG_LOW_ADDR, rd);
    chk("low reset", rd, 8'h00);
    io_rd(iet_pkg::TRIG_HIGH_ADDR, rd);
    chk("high reset", rd, 8'h00);
    // reserved bits stay zero in every write
    io_wr(iet_pkg::TRIG_LOW_ADDR, 8'hf8);
    io_wr(iet_pkg::TRIG_HIGH_ADDR, 8'hde);
    io_rd(iet_pkg::TRIG_LOW_ADDR, rd);
    chk("low rw", rd, 8'hf8);
    io_rd(iet_pkg::TRIG_HIGH_ADDR, rd);
    chk("high rw", rd, 8'hde);
    io_rd(16'h04d2, rd);
    chk("unmapped", rd, 8'h00);
    io_wr(iet_pkg::TRIG_LOW_ADDR, 8'h00);
    io_wr(iet_pkg::TRIG_HIGH_ADDR, 8'h00);
  endtask : t_regs

  task automatic t_edge();
    ack_en  <= 1'b0;
    ack_dly <= 4'h6;
    pulse(1);
    wait_int(1'b1, 12);
    repeat (12) @(posedge ref_clk_i);
    #1 chk("edge held", {7'h00, cpu_int_o}, 8'h01);
    ack_en <= 1'b1;
    wait_int(1'b0, 30);
    chk("kbd line", {4'h0, int_num_o}, 8'h01);
  endtask : t_edge

  task automatic t_level();
    io_wr(iet_pkg::TRIG_LOW_ADDR, 8'h20);
    ack_en <= 1'b0;
    pulse(5);
    wait_int(1'b1, 12);
    wait_int(1'b0, 12);
    io_wr(iet_pkg::TRIG_LOW_ADDR, 8'h00);
    io_wr(iet_pkg::MASTER_CMD_ADDR, 8'h18);
    pulse(0);
    wait_int(1'b1, 12);
    wait_int(1'b0, 12);
    io_wr(iet_pkg::MASTER_CMD_ADDR, 8'h10);
    io_wr(iet_pkg::SLAVE_CMD_ADDR, 8'h18);
    pulse(8);
    wait_int(1'b1, 12);
    wait_int(1'b0, 12);
    io_wr(iet_pkg::SLAVE_CMD_ADDR, 8'h10);
  endtask : t_level

  task automatic t_ce();
    @(posedge ref_clk_i);
    ce <= 1'b0;
    io_wr(iet_pkg::TRIG_LOW_ADDR, 8'h08);
    @(posedge ref_clk_i);
    ce <= 1'b1;
    io_rd(iet_pkg::TRIG_LOW_ADDR, rd);
    chk("ce frozen", rd, 8'h00);
  endtask : t_ce

  task automatic t_cascade();
    ack_en <= 1'b0;
    pulse(8);
    wait_int(1'b1, 14);
    io_rd(iet_pkg::MASTER_CMD_ADDR, rd);
    chk("master pend", rd & 8'h04, 8'h04);
    io_rd(iet_pkg::SLAVE_CMD_ADDR, rd);
    chk("slave pend", rd & 8'h01, 8'h01);
    ack_dly <= 4'h0;
    ack_en  <= 1'b1;
    wait_int(1'b0, 20);
    chk("rtc line", {4'h0, int_num_o}, 8'h08);
  endtask : t_cascade

  task automatic t_lines();
    int lst[4] = '{13, 14, 0, 3};
    foreach (lst[k]) begin
      pulse(lst[k]);
      wait_int(1'b1, 14);
      wait_int(1'b0, 20);
      chk("line num", {4'h0, int_num_o}, 8'(lst[k]));
    end
  endtask : t_lines

  task automatic t_nmi();
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      nmi_src[k] <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      nmi_src[k] <= 1'b0;
      #1 chk("nmi on", {6'h00, cpu_int_o, nmi_o}, 8'h01);
      repeat (8) @(posedge ref_clk_i);
      #1 chk("nmi off", {7'h00, nmi_o}, 8'h00);
    end
  endtask : t_nmi

  initial begin
    sys_rst_i  = 1'b1;
    io_addr_i  = 16'h0000;
    io_wr_i    = 1'b0;
    io_rd_i    = 1'b0;
    io_wdata_i = 8'h00;
    pins       = 16'h0000;
    nmi_src    = 2'b00;
    ack_en     = 1'b0;
    ce         = 1'b1;
    ack_dly    = 4'h0;
    n_mismatch   = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_ce();
    t_edge();
    t_level();
    t_cascade();
    t_lines();
    t_nmi();
    close_out();
  end
endmodule : tb_top
